// file: tb_top.sv
/* Self-checking bench for uaf_core, with a queue model of received data.
   Assumes uaf_ser_model as serialiser and uaf_chk bound at the foot. */
`timescale 1ns/1ns
module tb_top;
    import uaf_pkg::*;
    localparam int CH = 16 * 7 * 8;  // core clocks a character, reset line cfg
    logic          clock = 1'b0;
    logic          rst = 1'b1;
    logic          reg_wr = 1'b0;
    logic          reg_rd = 1'b0;
    logic          rx_push = 1'b0;
    logic          ring_n = 1'b1;
    logic          car_n = 1'b1;
    logic [2:0]    reg_addr = 3'h0;
    logic [7:0]    reg_wdata = 8'h00;
    logic [7:0]    reg_rdata_q;
    logic [7:0]    tx_data_q;
    logic [1:0]    aux_out_n_q;
    logic          tx_take, tx_shift_empty, tx_valid_q, rclk_in, loopback_q, irq_q;
    uaf_rx_char_t  rx_char = '0;
    uaf_line_cfg_t line_cfg_q;
    int            err_total = 0;
    int            n_checks = 0;
    int            seed = 76963;
    int            lv[4] = '{1, 4, 8, 14};
    logic [7:0]    q[$];
    logic [7:0]    v;
    uaf_core dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
        .rx_push, .rx_char, .tx_take, .tx_shift_empty, .tx_valid_q, .tx_data_q, .line_cfg_q,
        .rclk_in, .ring_indicate_in_n(ring_n), .carrier_detect_in_n(car_n), .aux_out_n_q,
        .loopback_q, .irq_q);
    uaf_ser_model ser (.clock, .rst, .tx_valid_q, .rclk_in, .tx_take, .tx_shift_empty);
    always #4 clock = ~clock;
    // ****
    // bus and stream tasks
    // ****
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input int n = 1);
        reg_wr <= 1'b1;
        for (int i = 0; i < n; i++) begin
            reg_addr <= a;
            reg_wdata <= d + 8'(i);
            @(posedge clock);
        end
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        chk(reg_rdata_q, exp);
    endtask
    task automatic push(input int n, input logic [2:0] e);
        logic [7:0] d;
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            q.push_back(d);
            rx_char <= {e, d};
            rx_push <= 1'b1;
            @(posedge clock);
        end
        rx_push <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(20000);
        err_total++;
        print_verdict();
    end
    // ****
    // scenarios
    // ****
    initial begin
        tick(2);
        rst <= 1'b0;
        tick(1);
        rd(3'h7, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(3'h7, v);
            rd(3'h7, v);
            ring_n <= i[0];
            car_n <= i[1];
            tick(8);
            rd(3'h6, {~i[1], ~i[0], 6'h00});
            wr(3'h4, {3'h0, 1'b1, i[1], i[0], 2'h0});
            rd(3'h6, {i[1], i[0], 6'h00});
            chk({5'h00, loopback_q, aux_out_n_q}, 8'h07);
            wr(3'h4, {4'h0, i[1], i[0], 2'h0});
            tick(1);
            chk({5'h00, loopback_q, aux_out_n_q}, {6'h00, ~i[1], ~i[0]});
        end
        // first empty after enabling queues comes at once
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h02);
        rd(3'h2, 8'hC2);
        rd(3'h2, 8'hC1);
        wr(3'h0, 8'h10, 3);
        rd(3'h5, 8'h00);
        chk(tx_data_q, 8'h11);
        tick(80);
        rd(3'h2, 8'hC2);
        rd(3'h5, 8'h60);
        // a lone byte delays the next empty indication
        wr(3'h0, 8'h5A);
        tick(300);
        rd(3'h2, 8'hC1);
        tick(600);
        rd(3'h2, 8'hC2);
        wr(3'h1, 8'h01);
        for (int t = 0; t < 4; t++) begin
            wr(3'h2, 8'(t * 64 + 3));
            q.delete();
            push(lv[t] - 1, 3'h0);
            rd(3'h2, 8'hC1);
            push(1, 3'h0);
            rd(3'h2, 8'hC4);
            chk({7'h00, irq_q}, 8'h01);
            rd(3'h0, q.pop_front());
            rd(3'h2, 8'hC1);
            chk({7'h00, irq_q}, 8'h00);
        end
        wr(3'h1, 8'h05);
        wr(3'h2, 8'h03);
        q.delete();
        push(1, 3'h2);
        rd(3'h5, 8'hE9);
        rd(3'h2, 8'hC6);
        wr(3'h1, 8'h00);
        rd(3'h2, 8'hC1);
        rd(3'h5, 8'hE9);
        push(3, 3'h0);
        rd(3'h0, q.pop_front());
        rd(3'h5, 8'h61);
        wr(3'h3, 8'h0F);
        chk({4'h0, line_cfg_q}, 8'h0F);
        wr(3'h3, 8'h00);
        // two characters below a high trigger level end in a timeout
        wr(3'h1, 8'h01);
        wr(3'h2, 8'hC3);
        q.delete();
        push(2, 3'h0);
        tick(4 * CH - 300);
        rd(3'h2, 8'hC1);
        tick(500);
        rd(3'h2, 8'hCC);
        rd(3'h0, q.pop_front());
        rd(3'h2, 8'hC1);
        print_verdict();
    end
endmodule
bind uaf_core uaf_chk u_chk (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .rx_push, .tx_valid_q, .loopback_q);

// file: uaf_chk.sv
/* Concurrent checks on the status block's register port.
   Assumes a bind onto uaf_core and a single clock domain. */
`timescale 1ns/1ns
module uaf_chk (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_q,
    input wire logic       rx_push,
    input wire logic       tx_valid_q,
    input wire logic       loopback_q
);
    logic [7:0] scr_q;
    logic [1:0] aux_q;
    wire rd_scr = reg_rd && reg_addr == 3'h7;
    wire rd_msr = reg_rd && reg_addr == 3'h6 && loopback_q;
    wire rd_lsr = reg_rd && reg_addr == 3'h5;
    wire rd_iir = reg_rd && reg_addr == 3'h2;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // ****
    // shadow of software writes
    // ****
    always_ff @(posedge clock) begin
        if (rst) begin
            scr_q <= 8'h00;
            aux_q <= 2'h0;
        end else if (reg_wr && reg_addr == 3'h7) begin
            scr_q <= reg_wdata;
        end else if (reg_wr && reg_addr == 3'h4) begin
            aux_q <= reg_wdata[3:2];
        end
    end
    property p_scr; rd_scr |=> reg_rdata_q == $past(scr_q); endproperty
    a_scr: assert property (p_scr) else $error("scratch readback wrong");
    property p_ri; rd_msr |=> reg_rdata_q[6] == aux_q[0]; endproperty
    a_ri: assert property (p_ri) else $error("loopback bit 6 wrong");
    property p_dcd; rd_msr |=> reg_rdata_q[7] == aux_q[1]; endproperty
    a_dcd: assert property (p_dcd) else $error("loopback bit 7 wrong");
    property p_dr; rx_push && !reg_wr ##1 rd_lsr |=> reg_rdata_q[0]; endproperty
    a_dr: assert property (p_dr) else $error("data ready missing");
    property p_tx_holding_empty_state; rd_lsr |=> reg_rdata_q[5] == !$past(tx_valid_q); endproperty
    a_tx_holding_empty_state: assert property (p_tx_holding_empty_state) else $error("holding empty wrong");
    property p_temt; rd_lsr |=> !reg_rdata_q[6] || !$past(tx_valid_q); endproperty
    a_temt: assert property (p_temt) else $error("all empty wrong");
    property p_iid;
        rd_iir |=> reg_rdata_q[5:4] == 2'h0 && (!reg_rdata_q[3] || reg_rdata_q[2] && reg_rdata_q[7]);
    endproperty
    a_iid: assert property (p_iid) else $error("id bits wrong");
    property p_txclr;
        rd_iir ##1 reg_rdata_q[3:0] == 4'h2 && !reg_wr ##1 rd_iir |=> reg_rdata_q[3:0] != 4'h2;
    endproperty
    a_txclr: assert property (p_txclr) else $error("tx empty not cleared");
endmodule

// file: uaf_core.sv
/*
 * Queue, interrupt identification, timeout and line status logic of a
 * queued asynchronous serial transceiver, with modem upper status bits
 * and a scratch register.
 * Assumes an external serialiser on the same clock that pushes received
 * characters and takes transmit characters, and a 16x receiver baud clock
 * arriving on a pin.
 */
// Contract
// - status bit 6 reads inverted ring input, or aux output 1 in loopback.
// - status bit 7 reads inverted carrier input, or aux output 2 in loopback.
// - eight-bit scratch register, read and write, affects nothing else.
// - queued mode, rx irq enabled: data irq while fill at or above trigger.
// - identification shows data-available code exactly while trigger reached.
// - line status code 06 outranks received data code 04.
// - data ready sets on character entry, clears only when queue is empty.
// - timeout when queue nonempty and four character times without push or read.
// - character times counted on the receiver baud clock input.
// - active timeout cleared and timer restarted by one host read.
// - inactive timeout timer restarts on new character or host read.
// - transmit empty code 02 set on empty queue, cleared by write or read.
// - empty indication delayed one character less stop unless two bytes held.
// - first transmit interrupt after queue enable change is immediate.
// - timeout and trigger share data priority; tx empty shares holding priority.
// - clearing enables puts receiver and transmitter independently in polling.
// - polled error bits behave as usual; identification untouched without enable.
// - holding empty status bit set while transmit queue holds nothing.
// - transmitter empty bit set only when queue and shifter both empty.
// - queue error bit set while any stored character carries an error; the code sets it only in queued mode.
// - polling shows no trigger or timeout, queues still store characters.
// - trigger select 00,01,10,11 gives 1, 4, 8, 14 bytes.
// - timeout sets identification bit 3 with bit 2, only in queued mode.
// - rx enable bit gates both data-available and timeout interrupts.
`timescale 1ns/1ns
`include "uaf_regs.svh"

module uaf_core
    import uaf_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [2:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output      logic [7:0]             reg_rdata_q,
    input  wire logic                   rx_push,
    input  wire uaf_pkg::uaf_rx_char_t  rx_char,
    input  wire logic                   tx_take,
    input  wire logic                   tx_shift_empty,
    output      logic                   tx_valid_q,
    output      logic [7:0]             tx_data_q,
    output      uaf_pkg::uaf_line_cfg_t line_cfg_q,
    input  wire logic                   rclk_in,
    input  wire logic                   ring_indicate_in_n,
    input  wire logic                   carrier_detect_in_n,
    output      logic [1:0]             aux_out_n_q,
    output      logic                   loopback_q,
    output      logic                   irq_q
);
    import uaf_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = PW + 1;

    // ****************************************
    // pin synchronisers: rclk, ring, carrier
    // ****************************************
    logic [2:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl_d;
    logic       tick;

    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < 3; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
                lvl_d[i] = sync3_q[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_q <= 3'h6;
            sync2_q <= 3'h6;
            sync3_q <= 3'h6;
            lvl_q   <= 3'h6;
        end else begin
            sync1_q <= {carrier_detect_in_n, ring_indicate_in_n, rclk_in};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            lvl_q   <= lvl_d;
        end
    end

    // one tick per rising edge of the receiver baud clock
    assign tick = lvl_d[0] & ~lvl_q[0];

    // ****************************************
    // shared decode and derived values
    // ****************************************
    logic [3:0]      ier_q, ier_d;
    logic            fifo_en_q, fifo_en_d;
    logic [1:0]      trig_q, trig_d;
    logic [4:0]      mcr_q, mcr_d;
    logic [7:0]      scr_q, scr_d, rdata_d;
    uaf_line_cfg_t   lcfg_d;
    logic [1:0]      aux_d;
    logic            irq_d;
    logic            wr_data, rd_data, wr_fcr, rd_iir, rd_lsr, mode_chg;
    logic            rx_clr, tx_clr;
    logic [CW-1:0]   cap, trig_lvl;
    logic [3:0]      char_bits;
    logic [9:0]      char_ticks, to_limit;

    assign wr_data  = reg_wr && reg_addr == `UAF_ADDR_DATA;
    assign rd_data  = reg_rd && reg_addr == `UAF_ADDR_DATA;
    assign wr_fcr   = reg_wr && reg_addr == `UAF_ADDR_IIR;
    assign rd_iir   = reg_rd && reg_addr == `UAF_ADDR_IIR;
    assign rd_lsr   = reg_rd && reg_addr == `UAF_ADDR_LSR;
    // toggling queue mode flushes both queues
    assign mode_chg = wr_fcr && reg_wdata[`UAF_FCR_EN] != fifo_en_q;
    assign rx_clr   = mode_chg || (wr_fcr && reg_wdata[`UAF_FCR_EN]
                      && reg_wdata[`UAF_FCR_RXCLR]);
    assign tx_clr   = mode_chg || (wr_fcr && reg_wdata[`UAF_FCR_EN]
                      && reg_wdata[`UAF_FCR_TXCLR]);
    // compatibility mode behaves as a one-deep holding register
    assign cap = fifo_en_q ? CW'(DEPTH) : CW'(1);

    always_comb begin
        unique case (trig_q)
            `UAF_TRIG_SEL_1: trig_lvl = CW'(`UAF_TRIG_1);
            `UAF_TRIG_SEL_4: trig_lvl = CW'(`UAF_TRIG_4);
            `UAF_TRIG_SEL_8: trig_lvl = CW'(`UAF_TRIG_8);
            default:         trig_lvl = CW'(`UAF_TRIG_14);
        endcase
    end

    // second stop bit counts toward the character time
    assign char_bits  = `UAF_CHAR_BASE + {2'h0, line_cfg_q.wlen}
                      + {3'h0, line_cfg_q.two_stop} + {3'h0, line_cfg_q.par_en};
    assign char_ticks = 10'({6'h00, char_bits} * `UAF_BIT_TICKS);
    assign to_limit   = 10'(char_ticks * `UAF_TO_CHARS);

    // ****************************************
    // receive queue and timeout
    // ****************************************
    uaf_rx_char_t   rx_mem [DEPTH];
    logic [PW-1:0]  rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
    logic [CW-1:0]  rx_cnt_q, rx_cnt_d, rx_err_q, rx_err_d;
    logic           ovr_q, ovr_d, to_q, to_d;
    logic [9:0]     to_cnt_q, to_cnt_d;
    logic           rx_ok, rx_pop, rx_full, to_hit;
    uaf_rx_char_t   rx_head;

    assign rx_head = rx_mem[rx_rp_q];
    assign rx_full = rx_cnt_q >= cap;
    assign rx_ok   = rx_push && !rx_full;
    assign rx_pop  = rd_data && rx_cnt_q != '0;
    assign to_hit  = fifo_en_q && ier_q[`UAF_IER_RX] && rx_cnt_q != '0
                   && to_cnt_q >= to_limit;

    always_comb begin
        rx_wp_d  = rx_wp_q;
        rx_rp_d  = rx_rp_q;
        rx_cnt_d = rx_cnt_q;
        rx_err_d = rx_err_q;
        // a new overrun wins over the clearing status read
        ovr_d    = (rx_push && rx_full) || (ovr_q && !rd_lsr);
        if (rx_ok) begin
            rx_wp_d = PW'(rx_wp_q + 1'b1);
        end
        if (rx_pop) begin
            rx_rp_d = PW'(rx_rp_q + 1'b1);
        end
        rx_cnt_d = CW'(rx_cnt_q + CW'(rx_ok) - CW'(rx_pop));
        rx_err_d = CW'(rx_err_q + CW'(rx_ok && (rx_char.brk | rx_char.frm | rx_char.par))
                 - CW'(rx_pop && (rx_head.brk | rx_head.frm | rx_head.par)));
        if (rx_clr) begin
            rx_wp_d  = '0;
            rx_rp_d  = '0;
            rx_cnt_d = '0;
            rx_err_d = '0;
        end
        // timer restarts on any data read; a push restarts it only while no timeout is active
        to_cnt_d = to_cnt_q;
        if (rx_pop || (rx_ok && !to_q) || rx_cnt_q == '0) begin
            to_cnt_d = '0;
        end else if (tick && !to_hit) begin
            to_cnt_d = 10'(to_cnt_q + 1'b1);
        end
        to_d = (to_hit && !to_q) || (to_q && !rx_pop && !rx_clr);
        if (!fifo_en_q || !ier_q[`UAF_IER_RX]) begin
            to_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rx_wp_q  <= '0;
            rx_rp_q  <= '0;
            rx_cnt_q <= '0;
            rx_err_q <= '0;
            ovr_q    <= 1'b0;
            to_q     <= 1'b0;
            to_cnt_q <= '0;
        end else begin
            rx_wp_q  <= rx_wp_d;
            rx_rp_q  <= rx_rp_d;
            rx_cnt_q <= rx_cnt_d;
            rx_err_q <= rx_err_d;
            ovr_q    <= ovr_d;
            to_q     <= to_d;
            to_cnt_q <= to_cnt_d;
        end
        if (rx_ok) begin
            rx_mem[rx_wp_q] <= rx_char;
        end
    end

    // ****************************************
    // transmit queue and empty interrupt
    // ****************************************
    logic [7:0]     tx_mem [DEPTH];
    logic [PW-1:0]  tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
    logic [CW-1:0]  tx_cnt_q, tx_cnt_d;
    logic           two_q, two_d, first_q, first_d, tx_holding_empty_state_q, tx_holding_empty_state_d;
    logic           dly_run_q, dly_run_d, tx_valid_d;
    logic [9:0]     dly_q, dly_d;
    logic [7:0]     tx_data_d;
    logic           tx_ok, tx_pop, tx_emptied, immediate, dly_done, tx_iir_clr;
    logic [3:0]     iir_code;

    assign tx_ok      = wr_data && tx_cnt_q < cap;
    assign tx_pop     = tx_take && tx_valid_q && tx_cnt_q != '0;
    assign tx_emptied = tx_cnt_q != '0 && tx_cnt_d == '0;
    assign immediate  = !fifo_en_q || two_q || first_q;
    assign dly_done   = dly_run_q && tick && dly_q <= 10'h001;
    assign tx_iir_clr = rd_iir && iir_code == `UAF_IIR_TX;

    always_comb begin
        tx_wp_d  = tx_wp_q;
        tx_rp_d  = tx_rp_q;
        if (tx_ok) begin
            tx_wp_d = PW'(tx_wp_q + 1'b1);
        end
        if (tx_pop) begin
            tx_rp_d = PW'(tx_rp_q + 1'b1);
        end
        tx_cnt_d = CW'(tx_cnt_q + CW'(tx_ok) - CW'(tx_pop));
        if (tx_clr) begin
            tx_wp_d  = '0;
            tx_rp_d  = '0;
            tx_cnt_d = '0;
        end
        // a write into an empty queue is the head before memory shows it
        if (tx_ok && tx_rp_d == tx_wp_q) begin
            tx_data_d = reg_wdata;
        end else begin
            tx_data_d = tx_mem[tx_rp_d];
        end
        tx_valid_d = tx_cnt_d != '0;
        // two bytes held together since the queue last emptied
        two_d   = (two_q && !tx_emptied) || tx_cnt_d >= CW'(2);
        first_d = mode_chg || (first_q && !tx_holding_empty_state_d);
        dly_run_d = dly_run_q;
        dly_d     = dly_q;
        tx_holding_empty_state_d    = tx_holding_empty_state_q && !tx_ok && !tx_iir_clr;
        if (tx_emptied || mode_chg) begin
            if (immediate || mode_chg) begin
                tx_holding_empty_state_d    = 1'b1;
                dly_run_d = 1'b0;
            end else begin
                dly_run_d = 1'b1;
                dly_d     = 10'(char_ticks - `UAF_BIT_TICKS);
            end
        end else if (tx_ok) begin
            dly_run_d = 1'b0;
        end else if (dly_done) begin
            tx_holding_empty_state_d    = 1'b1;
            dly_run_d = 1'b0;
        end else if (dly_run_q && tick) begin
            dly_d = 10'(dly_q - 1'b1);
        end
        // enabling the interrupt with an empty queue and no delay running raises it at once
        if (reg_wr && reg_addr == `UAF_ADDR_IER && reg_wdata[`UAF_IER_TX]
            && !ier_q[`UAF_IER_TX] && tx_cnt_q == '0 && !dly_run_q) begin
            tx_holding_empty_state_d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_wp_q    <= '0;
            tx_rp_q    <= '0;
            tx_cnt_q   <= '0;
            two_q      <= 1'b0;
            first_q    <= 1'b0;
            tx_holding_empty_state_q     <= 1'b0;
            dly_run_q  <= 1'b0;
            dly_q      <= '0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
        end else begin
            tx_wp_q    <= tx_wp_d;
            tx_rp_q    <= tx_rp_d;
            tx_cnt_q   <= tx_cnt_d;
            two_q      <= two_d;
            first_q    <= first_d;
            tx_holding_empty_state_q     <= tx_holding_empty_state_d;
            dly_run_q  <= dly_run_d;
            dly_q      <= dly_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q  <= tx_data_d;
        end
        if (tx_ok) begin
            tx_mem[tx_wp_q] <= reg_wdata;
        end
    end

    // ****************************************
    // status, identification and register file
    // ****************************************
    logic [7:0] line_status_reg, msr, interrupt_id_reg;
    logic       rx_avail, ls_irq;

    // error bits follow the character at the head, polled or not
    always_comb begin
        line_status_reg    = 8'h00;
        line_status_reg[0] = rx_cnt_q != '0;
        line_status_reg[1] = ovr_q;
        line_status_reg[2] = line_status_reg[0] & rx_head.par;
        line_status_reg[3] = line_status_reg[0] & rx_head.frm;
        line_status_reg[4] = line_status_reg[0] & rx_head.brk;
        line_status_reg[5] = tx_cnt_q == '0;
        line_status_reg[6] = line_status_reg[5] && tx_shift_empty;
        line_status_reg[7] = fifo_en_q && rx_err_q != '0;
    end

    always_comb begin
        msr    = 8'h00;
        msr[6] = mcr_q[`UAF_MCR_LOOP] ? mcr_q[`UAF_MCR_AUX1] : ~lvl_q[1];
        msr[7] = mcr_q[`UAF_MCR_LOOP] ? mcr_q[`UAF_MCR_AUX2] : ~lvl_q[2];
    end

    assign rx_avail = ier_q[`UAF_IER_RX] && (fifo_en_q ? rx_cnt_q >= trig_lvl
                      : rx_cnt_q != '0);
    assign ls_irq   = ier_q[`UAF_IER_LS] && |line_status_reg[4:1];

    always_comb begin
        if (ls_irq) begin
            iir_code = `UAF_IIR_LS;
        end else if (to_q) begin
            iir_code = `UAF_IIR_TO;
        end else if (rx_avail) begin
            iir_code = `UAF_IIR_RX;
        end else if (tx_holding_empty_state_q && ier_q[`UAF_IER_TX]) begin
            iir_code = `UAF_IIR_TX;
        end else begin
            iir_code = `UAF_IIR_NONE;
        end
    end

    assign interrupt_id_reg = {fifo_en_q, fifo_en_q, 2'b00, iir_code};

    always_comb begin
        ier_d     = ier_q;
        fifo_en_d = fifo_en_q;
        trig_d    = trig_q;
        lcfg_d    = line_cfg_q;
        mcr_d     = mcr_q;
        scr_d     = scr_q;
        if (reg_wr) begin
            unique case (reg_addr)
                `UAF_ADDR_IER:  ier_d  = reg_wdata[3:0];
                `UAF_ADDR_IIR: begin
                    fifo_en_d = reg_wdata[`UAF_FCR_EN];
                    // the other control bits need the enable bit set
                    if (reg_wdata[`UAF_FCR_EN]) begin
                        trig_d = reg_wdata[`UAF_FCR_TRIG_HI:`UAF_FCR_TRIG_LO];
                    end
                end
                `UAF_ADDR_LCFG: lcfg_d = reg_wdata[3:0];
                `UAF_ADDR_MCR:  mcr_d  = reg_wdata[4:0];
                `UAF_ADDR_SCR:  scr_d  = reg_wdata;
                default: ;
            endcase
        end
        rdata_d = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                `UAF_ADDR_DATA: rdata_d = rx_head.data;
                `UAF_ADDR_IER:  rdata_d = {4'h0, ier_q};
                `UAF_ADDR_IIR:  rdata_d = interrupt_id_reg;
                `UAF_ADDR_LCFG: rdata_d = {4'h0, line_cfg_q};
                `UAF_ADDR_MCR:  rdata_d = {3'h0, mcr_q};
                `UAF_ADDR_LSR:  rdata_d = line_status_reg;
                `UAF_ADDR_MSR:  rdata_d = msr;
                default:        rdata_d = scr_q;
            endcase
        end
        aux_d = mcr_q[`UAF_MCR_LOOP] ? 2'b11 : ~mcr_q[`UAF_MCR_AUX2:`UAF_MCR_AUX1];
        irq_d = iir_code != `UAF_IIR_NONE;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ier_q       <= `UAF_RST_IER;
            fifo_en_q   <= 1'b0;
            trig_q      <= `UAF_RST_TRIG;
            line_cfg_q  <= '0;
            mcr_q       <= `UAF_RST_MCR;
            scr_q       <= `UAF_RST_SCR;
            reg_rdata_q <= 8'h00;
            aux_out_n_q <= 2'b11;
            loopback_q  <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            ier_q       <= ier_d;
            fifo_en_q   <= fifo_en_d;
            trig_q      <= trig_d;
            line_cfg_q  <= lcfg_d;
            mcr_q       <= mcr_d;
            scr_q       <= scr_d;
            reg_rdata_q <= rdata_d;
            aux_out_n_q <= aux_d;
            loopback_q  <= mcr_q[`UAF_MCR_LOOP];
            irq_q       <= irq_d;
        end
    end

endmodule

// file: uaf_pkg.sv
/*
 * Types shared by the queued serial transceiver status block.
 * Assumes the register header sits in the same folder.
 */
package uaf_pkg;
    `include "uaf_regs.svh"

    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } uaf_rx_char_t;

    typedef struct packed {
        logic       par_en;
        logic       two_stop;
        logic [1:0] wlen;
    } uaf_line_cfg_t;
endpackage

// file: uaf_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * queued serial transceiver status block.
 * Assumes inclusion by the package and by the core module only.
 */
`ifndef UAF_REGS_SVH
`define UAF_REGS_SVH

// ****************************************
// register offsets (byte address, 3-bit)
// ****************************************
`define UAF_ADDR_DATA   3'h0
`define UAF_ADDR_IER    3'h1
`define UAF_ADDR_IIR    3'h2
`define UAF_ADDR_LCFG   3'h3
`define UAF_ADDR_MCR    3'h4
`define UAF_ADDR_LSR    3'h5
`define UAF_ADDR_MSR    3'h6
`define UAF_ADDR_SCR    3'h7

// ****************************************
// field positions
// ****************************************
`define UAF_IER_RX      0
`define UAF_IER_TX      1
`define UAF_IER_LS      2
`define UAF_FCR_EN      0
`define UAF_FCR_RXCLR   1
`define UAF_FCR_TXCLR   2
`define UAF_FCR_TRIG_LO 6
`define UAF_FCR_TRIG_HI 7
`define UAF_MCR_AUX1    2
`define UAF_MCR_AUX2    3
`define UAF_MCR_LOOP    4

// ****************************************
// identification codes
// ****************************************
`define UAF_IIR_NONE    4'h1
`define UAF_IIR_LS      4'h6
`define UAF_IIR_RX      4'h4
`define UAF_IIR_TO      4'hC
`define UAF_IIR_TX      4'h2

// ****************************************
// trigger levels and timing counts
// ****************************************
`define UAF_TRIG_SEL_1  2'h0
`define UAF_TRIG_SEL_4  2'h1
`define UAF_TRIG_SEL_8  2'h2
`define UAF_TRIG_1      5'h01
`define UAF_TRIG_4      5'h04
`define UAF_TRIG_8      5'h08
`define UAF_TRIG_14     5'h0E
`define UAF_CHAR_BASE   4'h7
`define UAF_BIT_TICKS   10'h010
`define UAF_TO_CHARS    10'h004

// ****************************************
// reset values
// ****************************************
`define UAF_RST_IER     4'h0
`define UAF_RST_MCR     5'h00
`define UAF_RST_SCR     8'h00
`define UAF_RST_TRIG    2'h0

`endif

// file: uaf_ser_model.sv
/* Behavioural serialiser and baud source facing the status block.
   Assumes the block's clock; shifts one character per SHIFT cycles. */
`timescale 1ns/1ns
module uaf_ser_model #(
    parameter int SHIFT = 20
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic tx_valid_q,
    output logic      rclk_in,
    output logic      tx_take = 1'b0,
    output logic      tx_shift_empty
);
    int busy = 0;
    // 16x baud clock of 8 core clocks, kept off the core edge
    initial begin
        rclk_in = 1'b0;
        #3;
        forever #32 rclk_in = ~rclk_in;
    end
    // one take pulse, then busy while the character goes out
    always @(posedge clock) begin
        if (rst) begin
            busy <= 0;
            tx_take <= 1'b0;
        end else begin
            tx_take <= tx_valid_q && busy == 0 && !tx_take;
            busy <= tx_take ? SHIFT : (busy > 0 ? busy - 1 : 0);
        end
    end
    assign tx_shift_empty = busy == 0 && !tx_take;
endmodule
